// ===== scp_regs.svh
// Offsets, field positions, reset values and pin map for the serial pin controller.
// Assumes a 32-bit classic Wishbone slave with byte addresses and two channels.
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// Register byte offsets
`define SCP_OFF_CTRL0     8'h00
`define SCP_OFF_CTRL1     8'h04
`define SCP_OFF_STAT0     8'h08
`define SCP_OFF_STAT1     8'h0C
`define SCP_OFF_VEC       8'h10
`define SCP_OFF_IUS       8'h14

// Channel control fields
`define SCP_F_RTS         0
`define SCP_F_DTR         1
`define SCP_F_AUTO        2
`define SCP_F_MODE        3
`define SCP_F_XTAL        5
`define SCP_F_DTR_REQ     6
`define SCP_F_WREQ_REQ    7
`define SCP_F_FACT        8
`define SCP_F_RTXC_USE    10
`define SCP_F_TRXC_OUT    12
`define SCP_F_TRXC_SEL    13
`define SCP_F_TRXC_TX     15
`define SCP_F_IE          16
`define SCP_CTRL_MASK     32'h0007_FFFF
`define SCP_CTRL_RST      32'h0000_0000

// Channel status fields: levels in [3:0], sticky change flags in [6:4]
`define SCP_F_CHG         4

// Global vector register fields
`define SCP_F_VEC         0
`define SCP_F_MIE         8
`define SCP_VEC_RST       9'h000

// Synchroniser vector positions
`define SCP_IN_CTS        0
`define SCP_IN_DCD        2
`define SCP_IN_SYNC       4
`define SCP_IN_RTXC       6
`define SCP_IN_TRXC       8
`define SCP_IN_ACK        10
`define SCP_IN_DS         11
`define SCP_IN_PRIO       12
`define SCP_NIN           13
`define SCP_FILT_RST      13'h0FFF

`endif

// ===== scp_pkg.sv
// Types shared by the serial pin controller.
// Assumes scp_regs.svh carries the register offsets, field positions and pin map.
package scp_pkg;
   typedef enum logic [3:0] {
      mode_async = 4'b0001,
      mode_ext   = 4'b0010,
      mode_int   = 4'b0100,
      mode_bitf  = 4'b1000
   } scp_sync_e;
   typedef logic [1:0] scp_ch_t;
endpackage

// ===== scp_pin_ctrl.sv
// Pin-level modem, sync, clock, daisy-chain and wait/request logic for two channels.
// Assumes the protocol engines sit on the same master clock and drive the i_ engine hooks.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "scp_regs.svh"

module scp_pin_ctrl (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic             i_wb_cyc,
   input  wire logic             i_wb_stb,
   input  wire logic             i_wb_we,
   input  wire logic [7:0]       i_wb_adr,
   input  wire logic [3:0]       i_wb_sel,
   input  wire logic [31:0]      i_wb_dat,
   output logic      [31:0]      o_wb_dat,
   output logic                  o_wb_ack,
   input  wire scp_pkg::scp_ch_t i_clear_to_send_n,
   input  wire scp_pkg::scp_ch_t i_carrier_detect_n,
   input  wire scp_pkg::scp_ch_t i_char_align_pin_n,
   output scp_pkg::scp_ch_t      o_char_align_pin_n,
   output scp_pkg::scp_ch_t      o_char_align_pin_n_oe,
   input  wire scp_pkg::scp_ch_t i_recv_xmit_clock_pin_n,
   input  wire scp_pkg::scp_ch_t i_xmit_recv_clock_pin_n,
   output scp_pkg::scp_ch_t      o_xmit_recv_clock_pin_n,
   output scp_pkg::scp_ch_t      o_xmit_recv_clock_pin_n_oe,
   output scp_pkg::scp_ch_t      o_request_to_send_n,
   output scp_pkg::scp_ch_t      o_terminal_ready_or_dma_req_n,
   output scp_pkg::scp_ch_t      o_wait_or_dma_req,
   output scp_pkg::scp_ch_t      o_wait_or_dma_req_oe,
   input  wire logic             i_prio_enable_in,
   output logic                  o_prio_enable_out,
   input  wire logic             i_irq_ack_n,
   input  wire logic             i_data_strobe_n,
   output logic                  o_irq_n,
   output logic                  o_irq_n_oe,
   output logic      [7:0]       o_vector_data,
   output logic                  o_vector_oe,
   input  wire scp_pkg::scp_ch_t i_tx_empty,
   input  wire scp_pkg::scp_ch_t i_sync_match,
   input  wire scp_pkg::scp_ch_t i_flag_rx,
   input  wire scp_pkg::scp_ch_t i_dma_req,
   input  wire scp_pkg::scp_ch_t i_wait_req,
   input  wire scp_pkg::scp_ch_t i_pll_out,
   input  wire scp_pkg::scp_ch_t i_osc_out,
   input  wire scp_pkg::scp_ch_t i_brg_out,
   input  wire scp_pkg::scp_ch_t i_tx_clk,
   output scp_pkg::scp_ch_t      o_tx_enable,
   output scp_pkg::scp_ch_t      o_rx_enable,
   output scp_pkg::scp_ch_t      o_rx_clk,
   output scp_pkg::scp_ch_t      o_tx_clk,
   output scp_pkg::scp_ch_t      o_brg_clk,
   output scp_pkg::scp_ch_t      o_pll_clk,
   output scp_pkg::scp_ch_t      o_rx_sample,
   output scp_pkg::scp_ch_t      o_assembly_start
);
   import scp_pkg::*;

   // ==========================================================
   // Helpers
   function automatic scp_sync_e mode_of(input logic [1:0] f);
      case (f)
         2'h0:    mode_of = mode_async;
         2'h1:    mode_of = mode_ext;
         2'h2:    mode_of = mode_int;
         default: mode_of = mode_bitf;
      endcase
   endfunction

   function automatic logic [5:0] factor_last(input logic [1:0] f);
      case (f)
         2'h0:    factor_last = 6'h00;
         2'h1:    factor_last = 6'h0F;
         2'h2:    factor_last = 6'h1F;
         default: factor_last = 6'h3F;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   // ==========================================================
   // Input synchroniser
   // Three stages; a level counts only once stages two and three agree.
   logic [`SCP_NIN-1:0] raw;
   logic [`SCP_NIN-1:0] s1_r;
   logic [`SCP_NIN-1:0] s2_r;
   logic [`SCP_NIN-1:0] s3_r;
   logic [`SCP_NIN-1:0] filt_r;
   logic [`SCP_NIN-1:0] filt_q_r;

   assign raw = {i_prio_enable_in, i_data_strobe_n, i_irq_ack_n, i_xmit_recv_clock_pin_n,
                 i_recv_xmit_clock_pin_n, i_char_align_pin_n, i_carrier_detect_n, i_clear_to_send_n};

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         s1_r     <= `SCP_FILT_RST;
         s2_r     <= `SCP_FILT_RST;
         s3_r     <= `SCP_FILT_RST;
         filt_r   <= `SCP_FILT_RST;
         filt_q_r <= `SCP_FILT_RST;
      end else begin
         s1_r     <= raw;
         s2_r     <= s1_r;
         s3_r     <= s2_r;
         filt_q_r <= filt_r;
         for (int i = 0; i < `SCP_NIN; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               filt_r[i] <= s3_r[i];
            end
         end
      end
   end

   logic ack_act;
   logic ds_act;
   logic prio_in;
   assign ack_act = !filt_r[`SCP_IN_ACK];
   assign ds_act  = !filt_r[`SCP_IN_DS];
   assign prio_in = filt_r[`SCP_IN_PRIO];

   // ==========================================================
   // Register bus
   logic [31:0] ctrl_r [2];
   logic [8:0]  vec_r;
   logic        ius_r;
   logic [2:0]  chg_r [2];
   logic        ack_r;
   logic [31:0] dat_r;
   logic        acc;
   logic        wr;
   logic [31:0] rd_val;

   // Vector register after byte-lane merge; only the low nine bits are kept
   logic [31:0] vec_wr;
   assign vec_wr   = merge({23'h0, vec_r}, i_wb_dat, i_wb_sel);
   assign acc      = i_wb_cyc && i_wb_stb && !ack_r;
   assign wr       = acc && i_wb_we;
   assign o_wb_ack = ack_r;
   assign o_wb_dat = dat_r;

   always_comb begin
      rd_val = 32'h0000_0000;
      if (i_wb_adr == `SCP_OFF_CTRL0) begin
         rd_val = ctrl_r[0];
      end else if (i_wb_adr == `SCP_OFF_CTRL1) begin
         rd_val = ctrl_r[1];
      end else if (i_wb_adr == `SCP_OFF_STAT0) begin
         rd_val = {25'h0, chg_r[0], i_tx_empty[0], ~filt_r[`SCP_IN_SYNC], ~filt_r[`SCP_IN_DCD],
                   ~filt_r[`SCP_IN_CTS]};
      end else if (i_wb_adr == `SCP_OFF_STAT1) begin
         rd_val = {25'h0, chg_r[1], i_tx_empty[1], ~filt_r[`SCP_IN_SYNC+1], ~filt_r[`SCP_IN_DCD+1],
                   ~filt_r[`SCP_IN_CTS+1]};
      end else if (i_wb_adr == `SCP_OFF_VEC) begin
         rd_val = {23'h0, vec_r};
      end else if (i_wb_adr == `SCP_OFF_IUS) begin
         rd_val = {31'h0, ius_r};
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= acc;
         if (acc && !i_wb_we) begin
            dat_r <= rd_val;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         ctrl_r[0] <= `SCP_CTRL_RST;
         ctrl_r[1] <= `SCP_CTRL_RST;
         vec_r     <= `SCP_VEC_RST;
      end else if (wr) begin
         if (i_wb_adr == `SCP_OFF_CTRL0) begin
            ctrl_r[0] <= merge(ctrl_r[0], i_wb_dat, i_wb_sel) & `SCP_CTRL_MASK;
         end else if (i_wb_adr == `SCP_OFF_CTRL1) begin
            ctrl_r[1] <= merge(ctrl_r[1], i_wb_dat, i_wb_sel) & `SCP_CTRL_MASK;
         end else if (i_wb_adr == `SCP_OFF_VEC) begin
            vec_r <= vec_wr[8:0];
         end
      end
   end

   // ==========================================================
   // Per-channel decode
   scp_sync_e mode [2];
   logic [1:0] auto_on;
   logic [1:0] xtal;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         mode[c]    = mode_of(ctrl_r[c][`SCP_F_MODE +: 2]);
         auto_on[c] = ctrl_r[c][`SCP_F_AUTO];
         xtal[c]    = ctrl_r[c][`SCP_F_XTAL];
      end
   end

   // ==========================================================
   // Modem status flags
   // Set wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         chg_r[0] <= 3'h0;
         chg_r[1] <= 3'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            logic [2:0] clr;
            logic [2:0] set;
            clr = (wr && i_wb_sel[0] && i_wb_adr == ((c == 0) ? `SCP_OFF_STAT0 : `SCP_OFF_STAT1)) ?
                  i_wb_dat[`SCP_F_CHG +: 3] : 3'h0;
            set[0] = filt_r[`SCP_IN_CTS+c] != filt_q_r[`SCP_IN_CTS+c];
            set[1] = filt_r[`SCP_IN_DCD+c] != filt_q_r[`SCP_IN_DCD+c];
            // Sync pin edges only matter as status while it is an input
            set[2] = (filt_r[`SCP_IN_SYNC+c] != filt_q_r[`SCP_IN_SYNC+c]) && !xtal[c] &&
                     (mode[c] == mode_async || mode[c] == mode_ext);
            chg_r[c] <= (chg_r[c] & ~clr) | set;
         end
      end
   end

   // ==========================================================
   // Interrupt pin and daisy chain
   logic irq_pend;
   logic owner_r;
   logic [7:0] vec_out_r;
   assign irq_pend = vec_r[`SCP_F_MIE] &&
                     |((chg_r[0] & ctrl_r[0][`SCP_F_IE +: 3]) | (chg_r[1] & ctrl_r[1][`SCP_F_IE +: 3]));

   assign o_irq_n           = 1'b0;
   assign o_irq_n_oe        = irq_pend && !ius_r;
   assign o_prio_enable_out = prio_in && !ius_r && !(ack_act && irq_pend);
   assign o_vector_data     = vec_out_r;
   assign o_vector_oe       = owner_r && ds_act && ack_act;

   // Grant is decided at the strobe's leading edge, after the chain has settled
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         owner_r   <= 1'b0;
         ius_r     <= 1'b0;
         vec_out_r <= 8'h00;
      end else begin
         if (ack_act && ds_act && filt_q_r[`SCP_IN_DS] && prio_in && irq_pend && !ius_r) begin
            owner_r   <= 1'b1;
            ius_r     <= 1'b1;
            vec_out_r <= vec_r[`SCP_F_VEC +: 8];
         end else begin
            if (!ds_act || !ack_act) begin
               owner_r <= 1'b0;
            end
            if (wr && i_wb_adr == `SCP_OFF_IUS && i_wb_sel[0] && i_wb_dat[0]) begin
               ius_r <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Modem outputs, gating and wait/request
   logic [1:0] rts_n_r;
   logic [1:0] dtr_n_r;
   logic [1:0] wq_o_r;
   logic [1:0] wq_oe_r;
   assign o_request_to_send_n           = rts_n_r;
   assign o_terminal_ready_or_dma_req_n = dtr_n_r;
   assign o_wait_or_dma_req             = wq_o_r;
   assign o_wait_or_dma_req_oe          = wq_oe_r;

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         o_tx_enable[c] = !auto_on[c] || !filt_r[`SCP_IN_CTS+c];
         o_rx_enable[c] = !auto_on[c] || !filt_r[`SCP_IN_DCD+c];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rts_n_r <= 2'h3;
         dtr_n_r <= 2'h3;
         wq_o_r  <= 2'h0;
         wq_oe_r <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (ctrl_r[c][`SCP_F_RTS]) begin
               rts_n_r[c] <= 1'b0;
            end else if (mode[c] == mode_async && auto_on[c] && !rts_n_r[c] && !i_tx_empty[c]) begin
               rts_n_r[c] <= 1'b0;
            end else begin
               rts_n_r[c] <= 1'b1;
            end
            dtr_n_r[c] <= ctrl_r[c][`SCP_F_DTR_REQ] ? !i_dma_req[c] : !ctrl_r[c][`SCP_F_DTR];
            // Wait is open-drain low only; request drives both levels
            if (ctrl_r[c][`SCP_F_WREQ_REQ]) begin
               wq_o_r[c]  <= !i_dma_req[c];
               wq_oe_r[c] <= 1'b1;
            end else begin
               wq_o_r[c]  <= 1'b0;
               wq_oe_r[c] <= i_wait_req[c];
            end
         end
      end
   end

   // ==========================================================
   // Sync pin
   logic [1:0] sy_o_r;
   logic [1:0] sy_oe_r;
   logic [1:0] start_r;
   assign o_char_align_pin_n    = sy_o_r;
   assign o_char_align_pin_n_oe = sy_oe_r;
   assign o_assembly_start      = start_r;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sy_o_r  <= 2'h3;
         sy_oe_r <= 2'h0;
         start_r <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            sy_o_r[c]  <= 1'b1;
            sy_oe_r[c] <= 1'b0;
            // The engine rewinds to the receive clock edge before this pulse
            start_r[c] <= mode[c] == mode_ext && !xtal[c] &&
                          filt_q_r[`SCP_IN_SYNC+c] && !filt_r[`SCP_IN_SYNC+c];
            if (!xtal[c] && mode[c] == mode_int) begin
               sy_oe_r[c] <= 1'b1;
               sy_o_r[c]  <= !i_sync_match[c];
            end else if (!xtal[c] && mode[c] == mode_bitf) begin
               sy_oe_r[c] <= 1'b1;
               sy_o_r[c]  <= !i_flag_rx[c];
            end
         end
      end
   end

   // ==========================================================
   // Clock pin routing and receive sampling factor
   logic [1:0] rx_r;
   logic [1:0] tx_r;
   logic [1:0] brg_r;
   logic [1:0] pll_r;
   logic [1:0] tr_o_r;
   logic [1:0] tr_oe_r;
   logic [1:0] rx_q_r;
   logic [1:0] smp_r;
   logic [5:0] cnt_r [2];
   assign o_rx_clk                   = rx_r;
   assign o_tx_clk                   = tx_r;
   assign o_brg_clk                  = brg_r;
   assign o_pll_clk                  = pll_r;
   assign o_xmit_recv_clock_pin_n    = tr_o_r;
   assign o_xmit_recv_clock_pin_n_oe = tr_oe_r;
   assign o_rx_sample                = smp_r;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         rx_r    <= 2'h0;
         tx_r    <= 2'h0;
         brg_r   <= 2'h0;
         pll_r   <= 2'h0;
         tr_o_r  <= 2'h3;
         tr_oe_r <= 2'h0;
         rx_q_r  <= 2'h0;
         smp_r   <= 2'h0;
         cnt_r[0] <= 6'h00;
         cnt_r[1] <= 6'h00;
      end else begin
         rx_q_r <= rx_r;
         for (int c = 0; c < 2; c++) begin
            logic       rt;
            logic       tr;
            logic [1:0] use_rt;
            logic       tr_in;
            rt     = !filt_r[`SCP_IN_RTXC+c] && !xtal[c];
            tr     = !filt_r[`SCP_IN_TRXC+c];
            use_rt = ctrl_r[c][`SCP_F_RTXC_USE +: 2];
            tr_in  = !ctrl_r[c][`SCP_F_TRXC_OUT];
            rx_r[c]  <= (use_rt == 2'h0 && rt) || (tr_in && !ctrl_r[c][`SCP_F_TRXC_TX] && tr);
            tx_r[c]  <= (use_rt == 2'h1 && rt) || (tr_in && ctrl_r[c][`SCP_F_TRXC_TX] && tr);
            brg_r[c] <= use_rt == 2'h2 && rt;
            pll_r[c] <= use_rt == 2'h3 && rt;
            tr_oe_r[c] <= !tr_in;
            case (ctrl_r[c][`SCP_F_TRXC_SEL +: 2])
               2'h0:    tr_o_r[c] <= !i_pll_out[c];
               2'h1:    tr_o_r[c] <= !i_osc_out[c];
               2'h2:    tr_o_r[c] <= !i_brg_out[c];
               default: tr_o_r[c] <= !i_tx_clk[c];
            endcase
            // One sample strobe per 1, 16, 32 or 64 receive clock rises
            smp_r[c] <= 1'b0;
            if (rx_r[c] && !rx_q_r[c]) begin
               if (cnt_r[c] >= factor_last(ctrl_r[c][`SCP_F_FACT +: 2])) begin
                  cnt_r[c] <= 6'h00;
                  smp_r[c] <= 1'b1;
               end else begin
                  cnt_r[c] <= cnt_r[c] + 6'h01;
               end
            end
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   tx_gate_a: assert property (auto_on[0] && filt_r[`SCP_IN_CTS] |-> !o_tx_enable[0])
      else $error("transmitter enabled while clear-to-send high");
   cts_event_a: assert property (filt_r[`SCP_IN_CTS] != filt_q_r[`SCP_IN_CTS] |=> chg_r[0][0])
      else $error("clear-to-send edge lost");
   rx_gate_a: assert property (auto_on[0] && filt_r[`SCP_IN_DCD] |-> !o_rx_enable[0])
      else $error("receiver enabled while carrier-detect high");
   dcd_event_a: assert property (filt_r[`SCP_IN_DCD] != filt_q_r[`SCP_IN_DCD] |=> chg_r[0][1])
      else $error("carrier-detect edge lost");
   dtr_pin_a: assert property (!ctrl_r[0][`SCP_F_DTR_REQ] && $stable(ctrl_r[0]) |=>
                               o_terminal_ready_or_dma_req_n[0] == !$past(ctrl_r[0][`SCP_F_DTR]))
      else $error("terminal-ready pin does not follow its bit");
   prio_block_a: assert property (ius_r || (ack_act && irq_pend) || !prio_in |-> !o_prio_enable_out)
      else $error("priority passed while blocked");
   irq_pull_a: assert property (irq_pend && !ius_r |-> o_irq_n_oe && !o_irq_n)
      else $error("pending request not on interrupt pin");
   vector_drive_a: assert property ($rose(o_vector_oe) |-> prio_in && ack_act && $past(prio_in))
      else $error("vector driven without priority");
   rts_set_a: assert property (ctrl_r[0][`SCP_F_RTS] |=> !o_request_to_send_n[0])
      else $error("request-to-send not low with bit set");
   rts_hold_a: assert property (mode[0] == mode_async && auto_on[0] && !o_request_to_send_n[0] &&
                                !i_tx_empty[0] |=> !o_request_to_send_n[0])
      else $error("request-to-send rose before transmitter empty");
   sync_int_a: assert property (mode[0] == mode_int && !xtal[0] && i_sync_match[0] |=>
                                o_char_align_pin_n_oe[0] && !o_char_align_pin_n[0])
      else $error("sync match not shown on pin");
   wait_mode_a: assert property (!ctrl_r[0][`SCP_F_WREQ_REQ] |=> !o_wait_or_dma_req[0])
      else $error("wait line driven high");

endmodule // scp_pin_ctrl
`default_nettype wire

// ===== scp_partner.sv
// Upstream daisy-chain neighbour and the shared open-drain interrupt wire.
// Assumes one higher-priority device whose request the bench commands.
`timescale 1ns/10ps
`default_nettype none
module scp_partner (
   input  wire logic i_clock,
   input  wire logic i_upper_req,
   input  wire logic i_irq_n_oe,
   output logic      o_prio_enable,
   output logic      o_irq_wire_n
);
   // ==========================================
   // Daisy chain: enable drops while the upper device wants service
   always_ff @(posedge i_clock) begin
      o_prio_enable <= !i_upper_req;
   end
   // Pull-up wins unless some party pulls the wire low
   assign o_irq_wire_n = !(i_irq_n_oe || i_upper_req);
endmodule // scp_partner
`default_nettype wire

// ===== scp_pin_ctrl_tb.sv
// Bench for scp_pin_ctrl: Wishbone register calls plus modem pin stimulus.
// Assumes scp_partner stands in for the upstream daisy neighbour.
`timescale 1ns/10ps
`default_nettype none
`include "scp_regs.svh"
module scp_pin_ctrl_tb;
   import scp_pkg::*;
   logic i_clock = 0, i_rst_n = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
   logic [7:0] i_wb_adr = '0, o_vector_data;
   logic [3:0] i_wb_sel = 4'hF;
   logic [31:0] i_wb_dat = '0, o_wb_dat, q;
   logic o_wb_ack, i_prio_enable_in, o_prio_enable_out, i_irq_ack_n = 1, i_data_strobe_n = 1;
   logic o_irq_n, o_irq_n_oe, o_vector_oe, upper_req = 0, irq_wire_n;
   scp_ch_t i_clear_to_send_n = 0, i_carrier_detect_n = 0, i_char_align_pin_n = 3, i_recv_xmit_clock_pin_n = 3;
   scp_ch_t i_xmit_recv_clock_pin_n = 3, i_tx_empty = 3, i_sync_match = 0, i_flag_rx = 0, i_dma_req = 0;
   scp_ch_t i_wait_req = 0, i_pll_out = 0, i_osc_out = 0, i_brg_out = 0, i_tx_clk = 0;
   scp_ch_t o_char_align_pin_n, o_char_align_pin_n_oe, o_xmit_recv_clock_pin_n, o_xmit_recv_clock_pin_n_oe;
   scp_ch_t o_request_to_send_n, o_terminal_ready_or_dma_req_n, o_wait_or_dma_req, o_wait_or_dma_req_oe;
   scp_ch_t o_tx_enable, o_rx_enable, o_rx_clk, o_tx_clk, o_brg_clk, o_pll_clk, o_rx_sample, o_assembly_start;
   int n_mismatch = 0, n_checks = 0;
   int n_smp = 0, n_start = 0;
   always #4 i_clock = !i_clock;
   // One-cycle pulses are totalled here so a scenario can compare counts
   always @(posedge i_clock) begin
      if (i_rst_n) begin
         n_smp <= n_smp + int'(o_rx_sample[1]);
         n_start <= n_start + int'(o_assembly_start[1]);
      end
   end
   scp_pin_ctrl uut (.*);
   scp_partner peer (.i_clock(i_clock), .i_upper_req(upper_req), .i_irq_n_oe(o_irq_n_oe),
      .o_prio_enable(i_prio_enable_in), .o_irq_wire_n(irq_wire_n));
   // ==========================================
   // Shared tasks
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // Holds the request until ack is sampled high; bounded so a dead slave ends the run
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      q = o_wb_dat;
      if (o_wb_ack !== 1'b1) begin
         n_mismatch++;
         end_of_test();
      end
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_clock);
   endtask
   // ==========================================
   // Scenarios
   initial begin
      tick(20);
      i_rst_n <= 1'b1;
      tick(1);
      chk(o_request_to_send_n, 2'b11);
      chk(o_wait_or_dma_req_oe, 2'b00);
      wb(1'b0, 8'h18, '0);
      chk(q, 32'h0000_0000);
      wb(1'b1, `SCP_OFF_CTRL0, 32'h0000_0003);
      tick(2);
      chk(o_request_to_send_n, 2'b10);
      chk(o_terminal_ready_or_dma_req_n, 2'b10);
      wb(1'b1, `SCP_OFF_CTRL1, 32'h0000_0005);
      i_clear_to_send_n <= 2'b10;
      i_carrier_detect_n <= 2'b10;
      tick(6);
      chk({o_tx_enable[1], o_rx_enable[1]}, 2'b00);
      i_clear_to_send_n <= 2'b00;
      i_carrier_detect_n <= 2'b00;
      tick(6);
      chk({o_tx_enable[1], o_rx_enable[1]}, 2'b11);
      wb(1'b0, `SCP_OFF_STAT1, '0);
      chk(q[5:4], 2'b11);
      wb(1'b1, `SCP_OFF_STAT1, 32'h0000_0030);
      wb(1'b0, `SCP_OFF_STAT1, '0);
      chk(q[5:4], 2'b00);
      i_tx_empty <= 2'b01;
      wb(1'b1, `SCP_OFF_CTRL1, 32'h0000_0004);
      tick(4);
      chk(o_request_to_send_n[1], 1'b0);
      i_tx_empty <= 2'b11;
      tick(4);
      chk(o_request_to_send_n[1], 1'b1);
      upper_req <= 1'b1;
      tick(8);
      chk(o_prio_enable_out, 1'b0);
      upper_req <= 1'b0;
      tick(8);
      chk({o_prio_enable_out, irq_wire_n}, 2'b11);
      wb(1'b1, `SCP_OFF_CTRL0, 32'h0000_0083);
      tick(2);
      chk({o_wait_or_dma_req_oe[0], o_wait_or_dma_req[0]}, 2'b11);
      // Interrupt on a clear-to-send edge, then one acknowledge cycle
      wb(1'b1, `SCP_OFF_STAT0, 32'h0000_0070);
      wb(1'b1, `SCP_OFF_CTRL0, 32'h0001_0083);
      wb(1'b1, `SCP_OFF_VEC, 32'h0000_01A5);
      chk(irq_wire_n, 1'b1);
      i_clear_to_send_n <= 2'b01;
      tick(6);
      chk({irq_wire_n, o_irq_n_oe, o_irq_n}, 3'b010);
      i_irq_ack_n <= 1'b0;
      tick(6); // Let the chain settle before the strobe
      chk(o_prio_enable_out, 1'b0);
      i_data_strobe_n <= 1'b0;
      tick(7);
      chk({o_vector_oe, o_vector_data, o_irq_n_oe, o_prio_enable_out}, 11'h694);
      i_data_strobe_n <= 1'b1;
      i_irq_ack_n <= 1'b1;
      tick(6);
      chk(o_vector_oe, 1'b0);
      // Still pending, but the upstream neighbour holds the chain: no vector
      wb(1'b1, `SCP_OFF_IUS, 32'h0000_0001);
      upper_req <= 1'b1;
      i_irq_ack_n <= 1'b0;
      tick(8);
      i_data_strobe_n <= 1'b0;
      tick(8);
      chk({o_vector_oe, o_irq_n_oe}, 2'b01);
      i_data_strobe_n <= 1'b1;
      i_irq_ack_n <= 1'b1;
      upper_req <= 1'b0;
      wb(1'b1, `SCP_OFF_STAT0, 32'h0000_0010);
      tick(2);
      chk(irq_wire_n, 1'b1);
      // Channel 1: sync match, clock pin output, receive clock factor, external sync
      i_brg_out <= 2'b10;
      wb(1'b1, `SCP_OFF_CTRL1, 32'h0000_5110);
      i_sync_match <= 2'b10;
      tick(2);
      chk({o_xmit_recv_clock_pin_n_oe[1], o_xmit_recv_clock_pin_n[1]}, 2'b10);
      chk({o_char_align_pin_n_oe[1], o_char_align_pin_n[1]}, 2'b10);
      i_sync_match <= 2'b00;
      tick(2);
      chk({o_char_align_pin_n_oe[1], o_char_align_pin_n[1]}, 2'b11);
      wb(1'b1, `SCP_OFF_CTRL1, 32'h0000_5100);
      repeat (32) begin
         i_recv_xmit_clock_pin_n[1] <= 1'b0;
         tick(4);
         i_recv_xmit_clock_pin_n[1] <= 1'b1;
         tick(4);
      end
      tick(4);
      chk(n_smp, 2);
      wb(1'b1, `SCP_OFF_CTRL1, 32'h0000_0008);
      i_char_align_pin_n <= 2'b01;
      tick(10);
      chk(n_start, 1);
      end_of_test();
   end
endmodule // scp_pin_ctrl_tb
`default_nettype wire
